// >>> data_decode.sv
// Combinational data address decode: bank, direct or indirect, and target class.
// Assumes status and pointer values come from registers on the same clock.
`timescale 1ns/10ps
module data_decode (
    input  wire logic [mem_map_pkg::OFFSET_W-1:0]    offset_i,
    input  wire logic [mem_map_pkg::BANK_W-1:0]      bank_i,
    input  wire logic                                irp_i,
    input  wire logic [mem_map_pkg::DATA_W-1:0]      pointer_i,
    output logic      [mem_map_pkg::DATA_ADDR_W-1:0] addr_o,
    output mem_map_pkg::target_t                     target_o
);
    logic [mem_map_pkg::OFFSET_W-1:0] eff_ofs;

    always_comb begin
        if (offset_i == mem_map_pkg::OFS_INDIRECT) begin
            addr_o = {irp_i, pointer_i};
        end else begin
            addr_o = {bank_i, offset_i};
        end
        eff_ofs = addr_o[mem_map_pkg::OFFSET_W-1:0] & mem_map_pkg::BANK_MAX_OFFSET;
        // A pointer aimed at the indirect slot itself reads zero and writes nothing
        if (eff_ofs == mem_map_pkg::OFS_INDIRECT) begin
            target_o = mem_map_pkg::TGT_NONE;
        end else if (eff_ofs == mem_map_pkg::OFS_STATUS) begin
            target_o = mem_map_pkg::TGT_STATUS;
        end else if (eff_ofs == mem_map_pkg::OFS_POINTER) begin
            target_o = mem_map_pkg::TGT_POINTER;
        end else if (eff_ofs <= mem_map_pkg::SFR_TOP) begin
            target_o = mem_map_pkg::TGT_EXT;
        end else begin
            target_o = mem_map_pkg::TGT_GPR;
        end
    end
endmodule

// >>> mem_map_pkg.sv
// Constants and carrier types for the program and banked data memory map.
// Assumes one core clock and an asynchronous active-low reset shared with the core.
// Overview of operation
// - Instruction fetch and data access use separate paths and may share a cycle.
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Only 4K words exist; fetches above them wrap onto stored words.
// - Any reset loads the program counter with address zero.
// - A taken interrupt loads the program counter with address four.
// - Status bits 6 and 5 select data bank 0 to 3.
// - Each bank spans offsets 00h to 7Fh, 128 bytes.
// - Low offsets of each bank decode to special function registers.
// - Offsets above the special function region decode to RAM storage.
// - Every bank decodes some locations to special function registers.
// - Frequently used special registers alias one physical register in every bank.
// - Data is reachable directly or through the indirect pointer register.
package mem_map_pkg;

    localparam int PC_W        = 13;
    localparam int PROG_W      = 14;
    localparam int PROG_IDX_W  = 12;
    localparam int PROG_DEPTH  = 4096;
    localparam int OFFSET_W    = 7;
    localparam int BANK_W      = 2;
    localparam int DATA_ADDR_W = 9;
    localparam int DATA_W      = 8;
    localparam int GPR_DEPTH   = 512;

    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR   = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP      = 13'h0001;

    localparam logic [OFFSET_W-1:0] BANK_MAX_OFFSET = 7'h7f;
    localparam logic [OFFSET_W-1:0] SFR_TOP         = 7'h1f;
    localparam logic [OFFSET_W-1:0] OFS_INDIRECT    = 7'h00;
    localparam logic [OFFSET_W-1:0] OFS_STATUS      = 7'h03;
    localparam logic [OFFSET_W-1:0] OFS_POINTER     = 7'h04;

    localparam int BANK_HI_BIT = 6;
    localparam int BANK_LO_BIT = 5;
    localparam int IRP_BIT     = 7;

    localparam logic [DATA_W-1:0] STATUS_RST  = 8'h00;
    localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_STATUS,
        TGT_POINTER,
        TGT_EXT,
        TGT_GPR
    } target_t;

    typedef struct packed {
        logic                valid;
        logic                wr;
        logic [OFFSET_W-1:0] offset;
        logic [DATA_W-1:0]   wdata;
    } data_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } data_rsp_t;

    typedef struct packed {
        logic                   valid;
        logic                   wr;
        logic [DATA_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]      wdata;
    } sfr_req_t;

    typedef struct packed {
        logic              valid;
        logic              wr;
        target_t           target;
        logic [DATA_W-1:0] rdata;
    } stage_t;

    typedef struct packed {
        logic [PC_W-1:0]   pc;
        logic [PROG_W-1:0] instr;
        logic              instr_valid;
        data_req_t         s1;
        stage_t            s2;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] indirect_pointer_register;
        sfr_req_t          sfr;
        data_rsp_t         rsp;
    } top_state_t;

endpackage

// >>> mem_map_top.sv
// Program counter, program store and banked data map for the core.
// Assumes the core drives fetch, branch and data requests from the same clock,
// and that other special registers answer sfr_rdata_i in the cycle of sfr_req_o.
`timescale 1ns/10ps
module mem_map_top (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_b_i,
    input  wire logic                                 fetch_en_i,
    input  wire logic                                 branch_i,
    input  wire logic      [mem_map_pkg::PC_W-1:0]    branch_addr_i,
    input  wire logic                                 irq_take_i,
    input  wire logic                                 prog_wr_i,
    input  wire logic      [mem_map_pkg::PC_W-1:0]    prog_waddr_i,
    input  wire logic      [mem_map_pkg::PROG_W-1:0]  prog_wdata_i,
    input  wire mem_map_pkg::data_req_t               dat_req_i,
    input  wire logic      [mem_map_pkg::DATA_W-1:0]  sfr_rdata_i,
    output logic           [mem_map_pkg::PC_W-1:0]    pc_o,
    output logic           [mem_map_pkg::PROG_W-1:0]  instr_o,
    output logic                                      instr_valid_o,
    output mem_map_pkg::data_rsp_t                    dat_rsp_o,
    output mem_map_pkg::sfr_req_t                     sfr_req_o,
    output logic           [mem_map_pkg::DATA_W-1:0]  status_o,
    output logic           [mem_map_pkg::DATA_W-1:0]  indirect_pointer_register_o
);
    mem_map_pkg::top_state_t                    s_r;
    mem_map_pkg::top_state_t                    s_nxt;
    logic [mem_map_pkg::PROG_W-1:0]             prog_rdata;
    logic [mem_map_pkg::DATA_W-1:0]             gpr_rdata;
    logic [mem_map_pkg::DATA_ADDR_W-1:0]        dec_addr;
    mem_map_pkg::target_t                       dec_target;
    logic [mem_map_pkg::BANK_W-1:0]             bank_sel;
    logic                                       gpr_we;

    // Bank bits come straight from the status register
    assign bank_sel = {s_r.status[mem_map_pkg::BANK_HI_BIT],
                       s_r.status[mem_map_pkg::BANK_LO_BIT]};

    // Program storage has its own port, so data traffic never stalls a fetch
    word_store #(
        .WIDTH (mem_map_pkg::PROG_W),
        .DEPTH (mem_map_pkg::PROG_DEPTH),
        .AW    (mem_map_pkg::PROG_IDX_W)
    ) u_prog_store (
        .clk_i   (clk_i),
        .we_i    (prog_wr_i),
        .waddr_i (prog_waddr_i[mem_map_pkg::PROG_IDX_W-1:0]),
        .wdata_i (prog_wdata_i),
        .raddr_i (s_r.pc[mem_map_pkg::PROG_IDX_W-1:0]),
        .rdata_o (prog_rdata)
    );

    data_decode u_decode (
        .offset_i  (s_r.s1.offset),
        .bank_i    (bank_sel),
        .irp_i     (s_r.status[mem_map_pkg::IRP_BIT]),
        .pointer_i (s_r.indirect_pointer_register),
        .addr_o    (dec_addr),
        .target_o  (dec_target)
    );

    assign gpr_we = s_r.s1.valid && s_r.s1.wr && (dec_target == mem_map_pkg::TGT_GPR);

    // Storage is indexed by full bank and offset; the special region of it stays unused
    word_store #(
        .WIDTH (mem_map_pkg::DATA_W),
        .DEPTH (mem_map_pkg::GPR_DEPTH),
        .AW    (mem_map_pkg::DATA_ADDR_W)
    ) u_gpr_store (
        .clk_i   (clk_i),
        .we_i    (gpr_we),
        .waddr_i (dec_addr),
        .wdata_i (s_r.s1.wdata),
        .raddr_i (dec_addr),
        .rdata_o (gpr_rdata)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.instr_valid = 1'b0;
        if (fetch_en_i) begin
            s_nxt.instr       = prog_rdata;
            s_nxt.instr_valid = 1'b1;
        end
        if (irq_take_i) begin
            s_nxt.pc = mem_map_pkg::INT_VECTOR;
        end else if (branch_i) begin
            s_nxt.pc = branch_addr_i;
        end else if (fetch_en_i) begin
            s_nxt.pc = s_r.pc + mem_map_pkg::PC_STEP;
        end

        // Stage 1: capture the request; stage 2: decode and act
        s_nxt.s1        = dat_req_i;
        s_nxt.s2.valid  = s_r.s1.valid;
        s_nxt.s2.wr     = s_r.s1.wr;
        s_nxt.s2.target = dec_target;
        unique case (dec_target)
            mem_map_pkg::TGT_NONE:    s_nxt.s2.rdata = mem_map_pkg::DATA_ZERO;
            mem_map_pkg::TGT_STATUS:  s_nxt.s2.rdata = s_r.status;
            mem_map_pkg::TGT_POINTER: s_nxt.s2.rdata = s_r.indirect_pointer_register;
            mem_map_pkg::TGT_EXT:     s_nxt.s2.rdata = mem_map_pkg::DATA_ZERO;
            mem_map_pkg::TGT_GPR:     s_nxt.s2.rdata = gpr_rdata;
        endcase
        if (s_r.s1.valid && s_r.s1.wr) begin
            if (dec_target == mem_map_pkg::TGT_STATUS) begin
                s_nxt.status = s_r.s1.wdata;
            end
            if (dec_target == mem_map_pkg::TGT_POINTER) begin
                s_nxt.indirect_pointer_register = s_r.s1.wdata;
            end
        end
        s_nxt.sfr.valid = s_r.s1.valid && (dec_target == mem_map_pkg::TGT_EXT);
        s_nxt.sfr.wr    = s_r.s1.wr;
        s_nxt.sfr.addr  = dec_addr;
        s_nxt.sfr.wdata = s_r.s1.wdata;

        // Stage 3: answer reads; external registers reply in the cycle of the request
        s_nxt.rsp.valid = s_r.s2.valid && !s_r.s2.wr;
        if (s_r.s2.target == mem_map_pkg::TGT_EXT) begin
            s_nxt.rsp.rdata = sfr_rdata_i;
        end else begin
            s_nxt.rsp.rdata = s_r.s2.rdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r        <= '0;
            s_r.pc     <= mem_map_pkg::RESET_VECTOR;
            s_r.status <= mem_map_pkg::STATUS_RST;
            s_r.indirect_pointer_register <= mem_map_pkg::POINTER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pc_o                        = s_r.pc;
    assign instr_o                     = s_r.instr;
    assign instr_valid_o               = s_r.instr_valid;
    assign dat_rsp_o                   = s_r.rsp;
    assign sfr_req_o                   = s_r.sfr;
    assign status_o                    = s_r.status;
    assign indirect_pointer_register_o = s_r.indirect_pointer_register;

    // Last program write, kept only for checking fetch wraparound
    logic                                 chk_wr_valid_r;
    logic [mem_map_pkg::PROG_IDX_W-1:0]   chk_wr_idx_r;
    logic [mem_map_pkg::PROG_W-1:0]       chk_wr_data_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chk_wr_valid_r <= 1'b0;
            chk_wr_idx_r   <= '0;
            chk_wr_data_r  <= '0;
        end else if (prog_wr_i) begin
            chk_wr_valid_r <= 1'b1;
            chk_wr_idx_r   <= prog_waddr_i[mem_map_pkg::PROG_IDX_W-1:0];
            chk_wr_data_r  <= prog_wdata_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_direct_req;
        dat_req_i.valid && dat_req_i.offset != mem_map_pkg::OFS_INDIRECT;
    endsequence

    sequence s_status_write;
        s_direct_req and (dat_req_i.wr && dat_req_i.offset == mem_map_pkg::OFS_STATUS);
    endsequence

    sequence s_pointer_write;
        s_direct_req and (dat_req_i.wr && dat_req_i.offset == mem_map_pkg::OFS_POINTER);
    endsequence

    sequence s_pointer_read;
        s_direct_req and (!dat_req_i.wr && dat_req_i.offset == mem_map_pkg::OFS_POINTER);
    endsequence

    sequence s_ext_direct;
        s_direct_req and (dat_req_i.offset <= mem_map_pkg::SFR_TOP
            && dat_req_i.offset != mem_map_pkg::OFS_STATUS
            && dat_req_i.offset != mem_map_pkg::OFS_POINTER);
    endsequence

    a_reset_vector_load: assert property (
        !$past(rst_b_i) |-> pc_o == mem_map_pkg::RESET_VECTOR)
        else $error("program counter not at reset vector after reset");

    a_interrupt_vector_load: assert property (
        irq_take_i |=> pc_o == mem_map_pkg::INT_VECTOR)
        else $error("program counter not at interrupt vector");

    a_pc_step_wrap: assert property (
        fetch_en_i && !irq_take_i && !branch_i
        |=> pc_o == mem_map_pkg::PC_W'($past(pc_o) + mem_map_pkg::PC_STEP))
        else $error("program counter did not step by one");

    a_fetch_wraps_around: assert property (
        fetch_en_i && !prog_wr_i && chk_wr_valid_r
        && pc_o[mem_map_pkg::PROG_IDX_W-1:0] == chk_wr_idx_r
        |=> instr_o == chk_wr_data_r && instr_valid_o)
        else $error("fetch above stored words did not wrap");

    a_concurrent_access: assert property (
        fetch_en_i && dat_req_i.valid && !dat_req_i.wr
        |=> instr_valid_o ##2 dat_rsp_o.valid)
        else $error("fetch and data access did not both complete");

    property p_bank_follows_status;
        logic [mem_map_pkg::DATA_W-1:0] v;
        (s_status_write, v = dat_req_i.wdata) |-> ##2 status_o == v;
    endproperty
    a_bank_select_write: assert property (p_bank_follows_status)
        else $error("status write did not reach bank select");

    property p_pointer_alias;
        logic [mem_map_pkg::DATA_W-1:0] v;
        (s_pointer_write, v = dat_req_i.wdata) |-> ##2 indirect_pointer_register_o == v;
    endproperty
    a_pointer_alias_write: assert property (p_pointer_alias)
        else $error("pointer write in some bank missed the shared register");

    a_pointer_alias_read: assert property (
        s_pointer_read |-> ##3 dat_rsp_o.valid
        && dat_rsp_o.rdata == $past(indirect_pointer_register_o, 2))
        else $error("pointer read did not return the shared register");

    a_sfr_region_decode: assert property (
        s_ext_direct |-> ##2 sfr_req_o.valid)
        else $error("low bank offset not sent to special registers");

    a_gpr_region_decode: assert property (
        (s_direct_req and dat_req_i.offset > mem_map_pkg::SFR_TOP) |-> ##2 !sfr_req_o.valid)
        else $error("storage offset leaked to special registers");

    property p_direct_address;
        logic [mem_map_pkg::OFFSET_W-1:0] o;
        (s_ext_direct, o = dat_req_i.offset) |-> ##2
            sfr_req_o.addr == {$past(status_o[mem_map_pkg::BANK_HI_BIT:mem_map_pkg::BANK_LO_BIT]), o};
    endproperty
    a_direct_address_form: assert property (p_direct_address)
        else $error("direct address not formed from bank bits and offset");

    a_indirect_address: assert property (
        s_r.s1.valid && s_r.s1.offset == mem_map_pkg::OFS_INDIRECT
        |-> dec_addr == {status_o[mem_map_pkg::IRP_BIT], indirect_pointer_register_o})
        else $error("indirect access not steered by the pointer register");

    // Program counter holds unless a fetch, branch or interrupt moves it
    a_branch_target_load: assert property (
        branch_i && !irq_take_i |=> pc_o == $past(branch_addr_i))
        else $error("branch target not loaded");

    a_pc_holds_idle: assert property (
        !fetch_en_i && !branch_i && !irq_take_i |=> $stable(pc_o))
        else $error("program counter moved while idle");

    a_fetch_pulse_only: assert property (
        !fetch_en_i |=> !instr_valid_o)
        else $error("fetch valid without a fetch");

    // Named steps of the data pipeline
    sequence s_data_read;
        dat_req_i.valid && !dat_req_i.wr;
    endsequence

    sequence s_status_read;
        s_direct_req and (!dat_req_i.wr && dat_req_i.offset == mem_map_pkg::OFS_STATUS);
    endsequence

    sequence s_ext_write;
        s_ext_direct and dat_req_i.wr;
    endsequence

    // Reads answer at a fixed depth and writes never do, so the core matches by count
    a_read_answer_time: assert property (
        s_data_read |-> ##3 dat_rsp_o.valid)
        else $error("data read not answered in time");

    a_write_no_answer: assert property (
        dat_req_i.valid && dat_req_i.wr |-> ##3 !dat_rsp_o.valid)
        else $error("data write produced an answer");

    a_status_alias_read: assert property (
        s_status_read |-> ##3 dat_rsp_o.rdata == $past(status_o, 2))
        else $error("status read did not return the shared register");

    property p_sfr_write_carry;
        logic [mem_map_pkg::DATA_W-1:0] v;
        (s_ext_write, v = dat_req_i.wdata) |-> ##2 sfr_req_o.wr && sfr_req_o.wdata == v;
    endproperty
    a_sfr_write_carry: assert property (p_sfr_write_carry)
        else $error("special register write lost its data");

    a_self_pointer_drop: assert property (
        s_r.s1.valid && dec_target == mem_map_pkg::TGT_NONE
        |-> !gpr_we ##1 (!sfr_req_o.valid && s_r.s2.rdata == mem_map_pkg::DATA_ZERO))
        else $error("pointer aimed at the indirect slot reached storage");

endmodule

// >>> sfr_side_model.sv
// Far-side model of the other special registers answering sfr_req_o.
// Assumes the same core clock; answers combinationally in the request cycle.
`timescale 1ns/10ps
module sfr_side_model (
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    input  wire mem_map_pkg::sfr_req_t             req_i,
    output logic      [mem_map_pkg::DATA_W-1:0]    rdata_o
);
    logic [mem_map_pkg::DATA_W-1:0] churn_r;

    // Outside a request the bus changes every cycle, so a stale value never matches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            churn_r <= 8'h00;
        end else begin
            churn_r <= churn_r + 8'h3b;
        end
    end

    assign rdata_o = req_i.valid ? (req_i.addr[7:0] ^ {6'h16, req_i.addr[8:7]}) : churn_r;
endmodule

// >>> testbench.sv
// Self-checking bench for the program and banked data memory map.
// Assumes the design package and sfr_side_model are compiled first.
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic fetch_en_i = 1'b0, branch_i = 1'b0, irq_take_i = 1'b0, prog_wr_i = 1'b0;
    logic [12:0] branch_addr_i = 13'h0000, prog_waddr_i = 13'h0000;
    logic [13:0] prog_wdata_i = 14'h0000;
    mem_map_pkg::data_req_t dat_req_i = '0;
    logic [7:0] sfr_rdata_i;
    logic [12:0] pc_o;
    logic [13:0] instr_o;
    logic instr_valid_o;
    mem_map_pkg::data_rsp_t dat_rsp_o;
    mem_map_pkg::sfr_req_t sfr_req_o;
    logic [7:0] status_o, indirect_pointer_register_o;
    logic [8:0] sfr_wr_seen = 9'h000;
    int err_total = 0, total_checks = 0, cyc = 0;

    always #2 clk_i = ~clk_i;

    mem_map_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .fetch_en_i(fetch_en_i),
        .branch_i(branch_i), .branch_addr_i(branch_addr_i), .irq_take_i(irq_take_i),
        .prog_wr_i(prog_wr_i), .prog_waddr_i(prog_waddr_i), .prog_wdata_i(prog_wdata_i),
        .dat_req_i(dat_req_i), .sfr_rdata_i(sfr_rdata_i), .pc_o(pc_o), .instr_o(instr_o),
        .instr_valid_o(instr_valid_o), .dat_rsp_o(dat_rsp_o), .sfr_req_o(sfr_req_o),
        .status_o(status_o), .indirect_pointer_register_o(indirect_pointer_register_o));

    sfr_side_model far_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(sfr_req_o),
        .rdata_o(sfr_rdata_i));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [13:0] word_of(input logic [11:0] a);
        return {2'h2, a} ^ 14'h0a5a;
    endfunction

    function automatic logic [7:0] far_val(input logic [8:0] a);
        return a[7:0] ^ {6'h16, a[8:7]};
    endfunction

    task automatic do_reset();
        @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
    endtask

    task automatic load_pc(input logic [12:0] a, input bit irq);
        @(negedge clk_i);
        branch_i = 1'b1;
        branch_addr_i = a;
        irq_take_i = irq;
        @(negedge clk_i);
        branch_i = 1'b0;
        irq_take_i = 1'b0;
    endtask

    task automatic fetch(input logic [12:0] exp_pc, input logic [13:0] exp_w);
        @(negedge clk_i);
        fetch_en_i = 1'b1;
        @(negedge clk_i);
        fetch_en_i = 1'b0;
        chk("instr_valid", 16'h1, {15'h0, instr_valid_o});
        chk("instr", {2'h0, exp_w}, {2'h0, instr_o});
        chk("pc", {3'h0, exp_pc}, {3'h0, pc_o});
    endtask

    // One data request, optionally with a fetch in the same cycle
    task automatic data_op(input bit wr, input logic [6:0] ofs, input logic [7:0] wd,
                           input bit fe, output logic [7:0] rd, output logic [8:0] sa,
                           output bit sv);
        int n;
        rd = 8'h00;
        sa = 9'h000;
        sv = 1'b0;
        @(negedge clk_i);
        dat_req_i = '{valid: 1'b1, wr: wr, offset: ofs, wdata: wd};
        fetch_en_i = fe;
        @(negedge clk_i);
        dat_req_i.valid = 1'b0;
        fetch_en_i = 1'b0;
        for (n = 0; n < 4; n++) begin
            if (sfr_req_o.valid === 1'b1) begin
                sv = 1'b1;
                sa = sfr_req_o.addr;
                sfr_wr_seen = {sfr_req_o.wr, sfr_req_o.wdata};
            end
            if (dat_rsp_o.valid === 1'b1) begin
                rd = dat_rsp_o.rdata;
            end
            @(negedge clk_i);
        end
    endtask

    task automatic wr_status(input logic [1:0] b, input bit irp);
        logic [7:0] rd;
        logic [8:0] sa;
        bit sv;
        data_op(1'b1, 7'h03, {irp, b, 5'h00}, 1'b0, rd, sa, sv);
        chk("status", {8'h0, irp, b, 5'h00}, {8'h0, status_o});
    endtask

    task automatic t_reset();
        chk("pc_rst", 16'h0, {3'h0, pc_o});
        chk("status_rst", 16'h0, {8'h0, status_o});
        chk("ptr_rst", 16'h0, {8'h0, indirect_pointer_register_o});
        load_pc(13'h0123, 1'b0);
        chk("pc_branch", 16'h0123, {3'h0, pc_o});
        do_reset();
        chk("pc_rst2", 16'h0, {3'h0, pc_o});
        $display("test reset done");
    endtask

    task automatic t_prog();
        int i;
        for (i = 0; i < 7; i++) begin
            @(negedge clk_i);
            prog_wr_i = 1'b1;
            prog_waddr_i = (i == 6) ? 13'h0fff : 13'(i);
            prog_wdata_i = word_of(prog_waddr_i[11:0]);
        end
        @(negedge clk_i);
        prog_wr_i = 1'b0;
        load_pc(13'h1fff, 1'b0);
        fetch(13'h0000, word_of(12'hfff));
        fetch(13'h0001, word_of(12'h000));
        load_pc(13'h1003, 1'b0);
        fetch(13'h1004, word_of(12'h003));
        $display("test program done");
    endtask

    task automatic t_irq();
        load_pc(13'h0a00, 1'b1);
        chk("pc_irq", 16'h0004, {3'h0, pc_o});
        fetch(13'h0005, word_of(12'h004));
        $display("test interrupt done");
    endtask

    task automatic t_banks();
        logic [7:0] rd;
        logic [8:0] sa;
        bit sv;
        int b;
        for (b = 0; b < 4; b++) begin
            wr_status(2'(b), 1'b0);
            data_op(1'b1, 7'h7f, 8'h10 + 8'(b), 1'b0, rd, sa, sv);
            data_op(1'b1, 7'h20, 8'h80 + 8'(b), 1'b0, rd, sa, sv);
            chk("ram_wr_no_ext", 16'h0, {15'h0, sv});
        end
        for (b = 3; b >= 0; b--) begin
            wr_status(2'(b), 1'b0);
            data_op(1'b0, 7'h7f, 8'h00, 1'b0, rd, sa, sv);
            chk("ram_top", {8'h0, 8'h10 + 8'(b)}, {8'h0, rd});
            data_op(1'b0, 7'h20, 8'h00, 1'b0, rd, sa, sv);
            chk("ram_low", {8'h0, 8'h80 + 8'(b)}, {8'h0, rd});
            chk("ram_no_ext", 16'h0, {15'h0, sv});
            data_op(1'b0, 7'h05, 8'h00, 1'b0, rd, sa, sv);
            chk("ext_seen", 16'h1, {15'h0, sv});
            chk("ext_addr", {7'h0, 2'(b), 7'h05}, {7'h0, sa});
            chk("ext_data", {8'h0, far_val({2'(b), 7'h05})}, {8'h0, rd});
            data_op(1'b0, 7'h1f, 8'h00, 1'b0, rd, sa, sv);
            chk("ext_top", {7'h0, 2'(b), 7'h1f}, {7'h0, sa});
            data_op(1'b1, 7'h05, 8'h40 + 8'(b), 1'b0, rd, sa, sv);
            chk("ext_wr", {7'h0, 1'b1, 8'h40 + 8'(b)}, {7'h0, sfr_wr_seen});
            chk("ext_wr_addr", {7'h0, 2'(b), 7'h05}, {7'h0, sa});
            chk("ext_wr_no_rsp", 16'h0, {8'h0, rd});
        end
        $display("test banks done");
    endtask

    task automatic t_mirror_indirect();
        logic [7:0] rd;
        logic [8:0] sa;
        bit sv;
        wr_status(2'h0, 1'b1);
        data_op(1'b1, 7'h04, 8'ha5, 1'b0, rd, sa, sv);
        chk("ptr", 16'h00a5, {8'h0, indirect_pointer_register_o});
        data_op(1'b1, 7'h00, 8'h77, 1'b0, rd, sa, sv);
        data_op(1'b0, 7'h00, 8'h00, 1'b0, rd, sa, sv);
        chk("ind_rd", 16'h0077, {8'h0, rd});
        wr_status(2'h3, 1'b0);
        data_op(1'b0, 7'h04, 8'h00, 1'b0, rd, sa, sv);
        chk("ptr_mirror", 16'h00a5, {8'h0, rd});
        chk("ptr_no_ext", 16'h0, {15'h0, sv});
        data_op(1'b0, 7'h03, 8'h00, 1'b0, rd, sa, sv);
        chk("status_mirror", 16'h0060, {8'h0, rd});
        load_pc(13'h0002, 1'b0);
        data_op(1'b0, 7'h25, 8'h00, 1'b1, rd, sa, sv);
        chk("direct_of_ind", 16'h0077, {8'h0, rd});
        chk("fetch_same_cycle", {2'h0, word_of(12'h002)}, {2'h0, instr_o});
        chk("pc_same_cycle", 16'h0003, {3'h0, pc_o});
        data_op(1'b1, 7'h04, 8'h80, 1'b0, rd, sa, sv);
        data_op(1'b1, 7'h00, 8'h55, 1'b0, rd, sa, sv);
        data_op(1'b0, 7'h00, 8'h00, 1'b0, rd, sa, sv);
        chk("ind_self", 16'h0, {8'h0, rd});
        chk("ind_self_no_ext", 16'h0, {15'h0, sv});
        $display("test mirror and indirect done");
    endtask

    initial begin
        do_reset();
        t_reset();
        t_prog();
        t_irq();
        t_banks();
        t_mirror_indirect();
        report_and_stop();
    end
endmodule

// >>> word_store.sv
// Word-wide storage array with one write port and one combinational read port.
// Assumes a single clock; contents are not reset.
`timescale 1ns/10ps
module word_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic             clk_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];
endmodule
